//--- hdl/mls_stall_detect.sv
// sensorless load measurement, stall detection and phase-lag compensation
//
// Contract
// - primary load value refreshed every full step
// - primary filter averages four successive measurements
// - no stall detection below lower velocity threshold
// - stop on stall halts ramp, velocity zero
// - stall stop sets driver status stall flag
// - cleared event resumes after zero wait time
// - secondary stall when result below 8-bit threshold
// - secondary result always computed, 0 to 510
// - four sub-measurements by crossing; unfiltered uses index 0
// - secondary filter averages latest four sub-measurements
// - phase lag stored, applied, then subtracted back
// - stall stop event cleared by writing one
// - primary result is 10 bits, high means light
// - filtered primary updates once per four steps
// - diag pulse only voltage mode, within velocity window
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`include "mls_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mls_stall_detect #(
   parameter int STEP_W = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // measurement front end and drive state
   input wire mls_pkg::mls_meas_t meas,
   input wire logic chopVoltageMode,
   input wire logic [STEP_W-1:0] stepInterval,
   // ramp generator and diagnostics
   output logic haltMotion,
   output logic velocityZero,
   output logic resumePulse,
   output logic diagStall,
   output logic secStallLevel,
   output logic signed [9:0] phaseOffset,
   output logic irq
);
   import mls_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   mls_cfg_t cfg_reg;
   logic [STEP_W-1:0] lowerThr_reg;
   logic [STEP_W-1:0] vModeThr_reg;
   logic [7:0] secThr_reg;
   logic [15:0] zeroWait_reg;
   logic [1:0] evt_reg;
   logic [1:0] mask_reg;
   logic [9:0] priRes_reg;
   logic [11:0] priAcc_reg;
   logic [1:0] priCnt_reg;
   logic [7:0] sub_reg [4];
   logic [8:0] secRes_reg;
   logic stallFlag_reg;
   logic waiting_reg;
   logic [15:0] waitCnt_reg;
   logic resume_reg;
   logic diag_reg;
   logic prevMode_reg;
   logic [7:0] lagStore_reg;
   logic signed [9:0] phase_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdMux;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire setupRd = psel & ~penable & ~pwrite;
   wire wrEn = psel & penable & pwrite;
   wire selCfg = paddr == `MLS_OFS_CONFIG;
   wire selLow = paddr == `MLS_OFS_LOWER_THR;
   wire selVm = paddr == `MLS_OFS_VMODE_THR;
   wire selThr = paddr == `MLS_OFS_SEC_THR;
   wire selWait = paddr == `MLS_OFS_ZERO_WAIT;
   wire selEvt = paddr == `MLS_OFS_EVENT;
   wire selMask = paddr == `MLS_OFS_MASK;
   wire selDrv = paddr == `MLS_OFS_DRIVER_STATUS_REGISTER;
   wire selSec = paddr == `MLS_OFS_SEC_RESULT;
   wire selSub = paddr == `MLS_OFS_SUB_MEAS;
   wire selPh = paddr == `MLS_OFS_PHASE;
   wire mapped = selCfg | selLow | selVm | selThr | selWait | selEvt | selMask |
                 selDrv | selSec | selSub | selPh;
   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = rdata_reg;

   // read selection
   always_comb begin
      rdMux = 32'h0000_0000;
      if (selCfg) begin
         rdMux[3:0] = cfg_reg;
      end else if (selLow) begin
         rdMux[STEP_W-1:0] = lowerThr_reg;
      end else if (selVm) begin
         rdMux[STEP_W-1:0] = vModeThr_reg;
      end else if (selThr) begin
         rdMux[7:0] = secThr_reg;
      end else if (selWait) begin
         rdMux[15:0] = zeroWait_reg;
      end else if (selEvt) begin
         rdMux[1:0] = evt_reg;
      end else if (selMask) begin
         rdMux[1:0] = mask_reg;
      end else if (selDrv) begin
         rdMux[9:0] = priRes_reg;
         rdMux[`MLS_DRV_STALL_BIT] = stallFlag_reg;
      end else if (selSec) begin
         rdMux[8:0] = secRes_reg;
      end else if (selSub) begin
         rdMux = {sub_reg[3], sub_reg[2], sub_reg[1], sub_reg[0]};
      end else if (selPh) begin
         rdMux[9:0] = phase_reg;
      end
   end

   // ----------------------------------------
   // primary estimator
   // ----------------------------------------
   wire [11:0] priSum = priAcc_reg + {2'h0, meas.primaryRaw};
   wire priLast = priCnt_reg == `MLS_FILT_LAST;
   wire priUpd = meas.fullStep & (~cfg_reg.priFiltEn | priLast);
   wire [9:0] priNew = cfg_reg.priFiltEn ? priSum[11:2] : meas.primaryRaw;

   // one result per full step, or one per four when filtered
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         priRes_reg <= 10'h000;
         priAcc_reg <= 12'h000;
         priCnt_reg <= 2'h0;
      end else if (meas.fullStep) begin
         if (priUpd) priRes_reg <= priNew;
         priAcc_reg <= (cfg_reg.priFiltEn & ~priLast) ? priSum : 12'h000;
         priCnt_reg <= cfg_reg.priFiltEn ? priCnt_reg + 2'h1 : 2'h0;
      end
   end

   // ----------------------------------------
   // secondary estimator
   // ----------------------------------------
   // unfiltered mode folds every crossing into index 0
   wire [1:0] subIdx = cfg_reg.secFiltEn ? meas.crossIdx : 2'h0;
   genvar g;
   for (g = 0; g < 4; g++) begin : gSub
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) sub_reg[g] <= 8'h00;
         else if (meas.crossStrobe && subIdx == 2'(g)) sub_reg[g] <= meas.subRaw;
      end
   end
   wire [9:0] secSum = {2'h0, sub_reg[0]} + {2'h0, sub_reg[1]} +
                       {2'h0, sub_reg[2]} + {2'h0, sub_reg[3]};
   // sum/2 is the mean with one extra precision bit
   wire [8:0] secNext = cfg_reg.secFiltEn ? secSum[9:1] : {sub_reg[0], 1'b0};
   wire [8:0] secThrExt = {1'b0, secThr_reg};
   assign secStallLevel = secRes_reg < secThrExt;

   // updated regardless of chopper mode or velocity window
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) secRes_reg <= 9'h000;
      else if (meas.fullStep) secRes_reg <= secNext;
   end

   // ----------------------------------------
   // stall detection, stop and restart
   // ----------------------------------------
   // long step interval means slow motor: detection stays off
   wire velOk = stepInterval <= lowerThr_reg;
   wire priStall = priUpd & velOk & ~chopVoltageMode & (priNew == 10'h000);
   wire diagCond = meas.fullStep & chopVoltageMode & velOk &
                   (stepInterval > vModeThr_reg) & (secNext < secThrExt);
   wire stallDet = priStall | diagCond;
   wire setStop = cfg_reg.stopOnStall & stallDet;
   wire clrStop = wrEn & selEvt & pwdata[`MLS_EVT_STALL_STOP];
   wire clrSec = wrEn & selEvt & pwdata[`MLS_EVT_SEC_STALL];
   wire startWait = clrStop & evt_reg[`MLS_EVT_STALL_STOP] & ~setStop;
   wire waitDone = waiting_reg & (waitCnt_reg == 16'h0000);

   // event bits: a set in the same cycle as a clear wins
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) evt_reg <= 2'h0;
      else begin
         evt_reg[`MLS_EVT_STALL_STOP] <= setStop | (evt_reg[0] & ~clrStop);
         evt_reg[`MLS_EVT_SEC_STALL] <= diagCond | (evt_reg[1] & ~clrSec);
      end
   end

   // zero wait countdown, cancelled by a fresh stall
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         waiting_reg <= 1'b0;
         waitCnt_reg <= 16'h0000;
         resume_reg <= 1'b0;
      end else begin
         resume_reg <= waitDone & ~setStop;
         if (setStop) waiting_reg <= 1'b0;
         else if (startWait) begin
            waiting_reg <= 1'b1;
            waitCnt_reg <= zeroWait_reg;
         end else if (waitDone) waiting_reg <= 1'b0;
         else if (waiting_reg) waitCnt_reg <= waitCnt_reg - 16'h0001;
      end
   end

   // driver status stall flag, held until motion resumes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stallFlag_reg <= 1'b0;
         diag_reg <= 1'b0;
      end else begin
         diag_reg <= diagCond;
         if (setStop) stallFlag_reg <= 1'b1;
         else if (resume_reg) stallFlag_reg <= 1'b0;
      end
   end
   assign haltMotion = evt_reg[`MLS_EVT_STALL_STOP] | waiting_reg;
   assign velocityZero = evt_reg[`MLS_EVT_STALL_STOP];
   assign resumePulse = resume_reg;
   assign diagStall = diag_reg;
   assign irq = |(evt_reg & mask_reg);

   // ----------------------------------------
   // phase-lag compensation
   // ----------------------------------------
   // coarse estimate: heavier load (low result) means larger lag
   wire [8:0] lagDiff = `MLS_SEC_MAX - secRes_reg;
   wire [7:0] lagEst = lagDiff[8:1];
   wire toCurrent = prevMode_reg & ~chopVoltageMode;
   wire toVoltage = ~prevMode_reg & chopVoltageMode;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prevMode_reg <= 1'b1;
         lagStore_reg <= 8'h00;
         phase_reg <= 10'sh000;
      end else begin
         prevMode_reg <= chopVoltageMode;
         if (toCurrent && cfg_reg.phaseLagEn) begin
            lagStore_reg <= lagEst;
            phase_reg <= phase_reg + $signed({2'h0, lagEst});
         end else if (toVoltage) begin
            lagStore_reg <= 8'h00;
            phase_reg <= phase_reg - $signed({2'h0, lagStore_reg});
         end
      end
   end
   assign phaseOffset = phase_reg;

   // ----------------------------------------
   // register writes and read capture
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= '0;
         lowerThr_reg <= `MLS_RST_LOWER_THR;
         vModeThr_reg <= `MLS_RST_VMODE_THR;
         secThr_reg <= `MLS_RST_SEC_THR;
         zeroWait_reg <= `MLS_RST_ZERO_WAIT;
         mask_reg <= 2'h0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         if (setupRd) rdata_reg <= rdMux;
         if (wrEn && selCfg) cfg_reg <= pwdata[3:0];
         if (wrEn && selLow) lowerThr_reg <= pwdata[STEP_W-1:0];
         if (wrEn && selVm) vModeThr_reg <= pwdata[STEP_W-1:0];
         if (wrEn && selThr) secThr_reg <= pwdata[7:0];
         if (wrEn && selWait) zeroWait_reg <= pwdata[15:0];
         if (wrEn && selMask) mask_reg <= pwdata[1:0];
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_pri_single: assert property (meas.fullStep && !cfg_reg.priFiltEn
      |=> priRes_reg == $past(meas.primaryRaw)) else $error("primary not refreshed");
   a_pri_average: assert property (meas.fullStep && cfg_reg.priFiltEn && priLast
      |=> priRes_reg == $past(priSum[11:2])) else $error("primary average wrong");
   a_pri_rate: assert property (cfg_reg.priFiltEn && !priLast && !priUpd
      |=> $stable(priRes_reg)) else $error("filtered primary updated early");
   a_vel_gate: assert property (stepInterval > lowerThr_reg
      |-> !stallDet) else $error("stall detected below velocity");
   a_stop_halt: assert property (setStop
      |=> haltMotion && velocityZero && stallFlag_reg) else $error("stall did not halt");
   a_resume_count: assert property (waiting_reg && waitCnt_reg != 16'h0000 && !setStop
      |=> waitCnt_reg == $past(waitCnt_reg) - 16'h0001 && !resumePulse)
      else $error("zero wait miscounted");
   a_event_clear: assert property (clrStop && !setStop
      |=> !evt_reg[0]) else $error("stall event not cleared");
   a_diag_pulse: assert property (diagStall
      |-> $past(chopVoltageMode) && $past(secNext) < $past(secThrExt))
      else $error("diag pulse without cause");
   a_sec_unfilt: assert property (meas.fullStep && !cfg_reg.secFiltEn
      |=> secRes_reg == {$past(sub_reg[0]), 1'b0}) else $error("secondary scale wrong");
   a_phase_back: assert property (toVoltage
      |=> phase_reg == $past(phase_reg) - $signed({2'h0, $past(lagStore_reg)}))
      else $error("phase offset not removed");

   c_stall_stop: cover property (setStop ##1 haltMotion);
   c_resume: cover property (startWait ##[1:40] resumePulse);
   c_diag: cover property (diagStall && irq);
endmodule
`default_nettype wire

//--- hdl/mls_map.svh
// register map, field positions and reset values of the load and stall detector
`ifndef MLS_MAP_SVH
`define MLS_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MLS_OFS_CONFIG 8'h00
`define MLS_OFS_LOWER_THR 8'h04
`define MLS_OFS_VMODE_THR 8'h08
`define MLS_OFS_SEC_THR 8'h0C
`define MLS_OFS_ZERO_WAIT 8'h10
`define MLS_OFS_EVENT 8'h14
`define MLS_OFS_MASK 8'h18
`define MLS_OFS_DRIVER_STATUS_REGISTER 8'h1C
`define MLS_OFS_SEC_RESULT 8'h20
`define MLS_OFS_SUB_MEAS 8'h24
`define MLS_OFS_PHASE 8'h28
// ----------------------------------------
// field positions
// ----------------------------------------
`define MLS_EVT_STALL_STOP 0
`define MLS_EVT_SEC_STALL 1
`define MLS_DRV_STALL_BIT 24
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define MLS_RST_SEC_THR 8'h00
`define MLS_RST_ZERO_WAIT 16'h0000
`define MLS_RST_LOWER_THR 20'h00000
`define MLS_RST_VMODE_THR 20'h00000
`define MLS_SEC_MAX 9'h1FE
`define MLS_FILT_LAST 2'h3
`endif

//--- hdl/mls_pkg.sv
// types shared by the load and stall detector
package mls_pkg;
   // configuration bits written by software
   typedef struct packed {
      logic phaseLagEn;
      logic secFiltEn;
      logic priFiltEn;
      logic stopOnStall;
   } mls_cfg_t;
   // measurement front end, same clock domain
   typedef struct packed {
      logic fullStep;
      logic [9:0] primaryRaw;
      logic crossStrobe;
      logic [1:0] crossIdx;
      logic [7:0] subRaw;
   } mls_meas_t;
endpackage

//--- verification/mls_motor_model.sv
// far-side model: coil zero crossings and full steps for the detector
`timescale 1ns/1ps
`default_nettype none
module mls_motor_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // step request from the bench, halt from the detector
   input wire logic go,
   input wire logic single,
   input wire logic [9:0] priVal,
   input wire logic [31:0] subVals,
   input wire logic haltMotion,
   // to the detector
   output var mls_pkg::mls_meas_t meas
);
   import mls_pkg::*;
   logic [2:0] cnt_reg;
   logic [1:0] idx;
   logic strobe;
   logic stepDone;
   // ----------------------------------------
   // crossing and step strobes
   // ----------------------------------------
   assign idx = cnt_reg[1:0] - 2'h1;
   // single drives report only the first crossing, on index 0
   assign strobe = (cnt_reg != 3'h0) && (cnt_reg < 3'h5) && (!single || cnt_reg == 3'h1);
   assign stepDone = (cnt_reg == 3'h5);
   // one driver for the whole bundle; data off the strobe are inverted so a stale capture shows
   assign meas = '{fullStep: stepDone,
                   primaryRaw: stepDone ? priVal : ~priVal,
                   crossStrobe: strobe,
                   crossIdx: idx,
                   subRaw: strobe ? subVals[{idx, 3'h0} +: 8] : ~subVals[{idx, 3'h0} +: 8]};
   // a halted ramp starts no new step
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 3'h0;
      end else if (cnt_reg != 3'h0) begin
         cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
      end else if (go && !haltMotion) begin
         cnt_reg <= 3'h1;
      end
   end
endmodule
`default_nettype wire

//--- verification/mls_stall_detect_bench.sv
// self-checking bench for the load and stall detector
`include "mls_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mls_stall_detect_bench;
   import mls_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   mls_meas_t meas;
   logic chopMode = 1'b0;
   logic [19:0] stepIv = 20'h00032;
   logic haltMotion, velocityZero, resumePulse, diagStall, secStallLevel, irq;
   logic signed [9:0] phaseOffset;
   logic go = 1'b0;
   logic single = 1'b1;
   logic [9:0] priVal = 10'h000;
   logic [31:0] subVals = 32'h0;
   int n_fail = 0;
   int cmp_count = 0;
   int diagCnt = 0;
   int n, dc;
   always #20 sys_clk = ~sys_clk;
   // diag pulses last one cycle, so they are counted rather than polled
   always @(posedge sys_clk) if (diagStall === 1'b1) diagCnt++;
   mls_stall_detect #(.STEP_W(20)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas(meas), .chopVoltageMode(chopMode),
      .stepInterval(stepIv), .haltMotion(haltMotion), .velocityZero(velocityZero),
      .resumePulse(resumePulse), .diagStall(diagStall), .secStallLevel(secStallLevel),
      .phaseOffset(phaseOffset), .irq(irq));
   mls_motor_model MOTOR (.sys_clk(sys_clk), .reset_n(reset_n), .go(go), .single(single),
      .priVal(priVal), .subVals(subVals), .haltMotion(haltMotion), .meas(meas));
   // ----------------------------------------
   // bus, step and compare tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // the access phase ends only when pready is seen high
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic step(input logic [9:0] p, input logic [31:0] s, input logic one);
      @(posedge sys_clk);
      priVal <= p;
      subVals <= s;
      single <= one;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // watchdog and main sequence
   // ----------------------------------------
   initial begin
      #400000;
      n_fail++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      rdchk(`MLS_OFS_CONFIG, 32'hF, 32'h0);
      rdchk(`MLS_OFS_SEC_THR, 32'hFF, 32'h0);
      rdchk(`MLS_OFS_EVENT, 32'h3, 32'h0);
      apb(1'b1, 8'h3C, 32'h1);
      rdchk(8'h3C, 32'hFFFFFFFF, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("reset and map test done");
      apb(1'b1, `MLS_OFS_LOWER_THR, 32'h64);
      step(10'h12C, 32'h0, 1'b1);
      rdchk(`MLS_OFS_DRIVER_STATUS_REGISTER, 32'h3FF, 32'h12C);
      step(10'h3FF, 32'h0, 1'b1);
      rdchk(`MLS_OFS_DRIVER_STATUS_REGISTER, 32'h3FF, 32'h3FF);
      apb(1'b1, `MLS_OFS_CONFIG, 32'h2);
      for (int i = 0; i < 8; i++) step((i < 4) ? 10'h0C8 : 10'h258, 32'h0, 1'b1);
      rdchk(`MLS_OFS_DRIVER_STATUS_REGISTER, 32'h3FF, 32'h258);
      step(10'h000, 32'h0, 1'b1);
      rdchk(`MLS_OFS_DRIVER_STATUS_REGISTER, 32'h3FF, 32'h258);
      $display("primary test done");
      apb(1'b1, `MLS_OFS_CONFIG, 32'h1);
      apb(1'b1, `MLS_OFS_MASK, 32'h1);
      stepIv <= 20'h000C8;
      step(10'h000, 32'h0, 1'b1);
      rdchk(`MLS_OFS_EVENT, 32'h1, 32'h0);
      stepIv <= 20'h00064;
      step(10'h000, 32'h0, 1'b1);
      chk({29'h0, haltMotion, velocityZero, irq}, 32'h7);
      rdchk(`MLS_OFS_DRIVER_STATUS_REGISTER, 32'h1000000, 32'h1000000);
      apb(1'b1, `MLS_OFS_MASK, 32'h0);
      // the mask lands at the access edge, so irq is only settled one edge later
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `MLS_OFS_ZERO_WAIT, 32'h5);
      apb(1'b1, `MLS_OFS_EVENT, 32'h1);
      @(posedge sys_clk);
      chk({30'h0, haltMotion, velocityZero}, 32'h2);
      n = 1;
      while (resumePulse !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      chk({31'h0, n >= 6 && n <= 9}, 32'h1);
      apb(1'b1, `MLS_OFS_CONFIG, 32'h0);
      rdchk(`MLS_OFS_DRIVER_STATUS_REGISTER, 32'h1000000, 32'h0);
      chk({31'h0, haltMotion}, 32'h0);
      $display("stall stop test done");
      apb(1'b1, `MLS_OFS_SEC_THR, 32'h64);
      apb(1'b1, `MLS_OFS_VMODE_THR, 32'hA);
      stepIv <= 20'h00032;
      chopMode <= 1'b1;
      dc = diagCnt;
      step(10'h1F4, 32'h28, 1'b1);
      rdchk(`MLS_OFS_SEC_RESULT, 32'h1FF, 32'h50);
      chk({30'h0, secStallLevel, diagCnt == dc + 1}, 32'h3);
      rdchk(`MLS_OFS_EVENT, 32'h2, 32'h2);
      chopMode <= 1'b0;
      step(10'h1F4, 32'h28, 1'b1);
      rdchk(`MLS_OFS_SEC_RESULT, 32'h1FF, 32'h50);
      chk({31'h0, diagCnt == dc + 1}, 32'h1);
      chopMode <= 1'b1;
      stepIv <= 20'h00005;
      // result still below threshold, but the interval is outside the voltage-mode window
      step(10'h1F4, 32'h28, 1'b1);
      chk({31'h0, diagCnt == dc + 1}, 32'h1);
      chk({31'h0, secStallLevel}, 32'h1);
      apb(1'b1, `MLS_OFS_CONFIG, 32'h4);
      step(10'h1F4, 32'h281E140A, 1'b0);
      rdchk(`MLS_OFS_SEC_RESULT, 32'h1FF, 32'h32);
      rdchk(`MLS_OFS_SUB_MEAS, 32'hFFFFFFFF, 32'h281E140A);
      step(10'h1F4, 32'hFFFFFFFF, 1'b0);
      rdchk(`MLS_OFS_SEC_RESULT, 32'h1FF, 32'h1FE);
      chk({31'h0, secStallLevel}, 32'h0);
      $display("secondary test done");
      apb(1'b1, `MLS_OFS_CONFIG, 32'hC);
      step(10'h1F4, 32'h19191919, 1'b0);
      chopMode <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk({22'h0, phaseOffset}, 32'hE6);
      rdchk(`MLS_OFS_PHASE, 32'h3FF, 32'hE6);
      chopMode <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk({22'h0, phaseOffset}, 32'h0);
      $display("phase lag test done");
      stop_test;
   end
endmodule
`default_nettype wire
